/* src/adcc_cfg.svh */
// adc control constants: register indices, field positions, codes, counts
// assumes it is included by bare name with the include path set to src/
`ifndef ADCC_CFG_SVH
`define ADCC_CFG_SVH
// register indices, the byte address is four times the index
`define ADCC_IDX_RES_LO 10'h078
`define ADCC_IDX_RES_HI 10'h079
`define ADCC_IDX_CTRL   10'h07a
`define ADCC_IDX_CTRL_B 10'h07b
`define ADCC_IDX_SEL    10'h07c
// control/status fields
`define ADCC_CS_EN    7
`define ADCC_CS_START 6
`define ADCC_CS_ATE   5
`define ADCC_CS_FLAG  4
`define ADCC_CS_IE    3
`define ADCC_CS_PS    2:0
// channel/reference select and control b fields
`define ADCC_SEL_REF  7:6
`define ADCC_SEL_LADJ 5
`define ADCC_SEL_CH   3:0
`define ADCC_CB_TS    2:0
// reference, channel, trigger and prescaler codes
`define ADCC_REF_EXT    2'h0
`define ADCC_REF_AVCC   2'h1
`define ADCC_REF_INT    2'h3
`define ADCC_CH_EXT_MAX 4'h7
`define ADCC_CH_TEMP    4'h8
`define ADCC_CH_BG      4'he
`define ADCC_CH_GND     4'hf
`define ADCC_TS_FREE    3'h0
`define ADCC_PS_DIV2    3'h0
// converter clock cycles per conversion
`define ADCC_CONV_NORM  5'h0d
`define ADCC_CONV_FIRST 5'h19
`endif

/* src/adcc_pkg.sv */
// adc control shared types: sar states and the analog drive bundle
// assumes nothing beyond a systemverilog compile unit
package adcc_pkg;
  typedef enum logic [1:0] {SAR_IDLE, SAR_INIT, SAR_SAMPLE, SAR_TRIAL} adcc_sar_st_t;
  // drive toward the analog front end
  typedef struct packed {
    logic       power_on;
    logic       sample_hold;
    logic [9:0] dac_code;
    logic [7:0] ext_sel;
    logic       temp_en;
    logic       bandgap_sel;
    logic       ground_sel;
    logic       ref_ext;
    logic       ref_avcc;
    logic       ref_int;
  } adcc_anlg_t;
endpackage

/* src/adcc_prescale.sv */
// adc control converter clock divider, one-cycle tick per converter clock
// assumes run low while the converter is off
`timescale 1ns/100ps
`include "adcc_cfg.svh"
module adcc_prescale
  import adcc_pkg::*;
#(
  parameter int CNT_W = 7
) (
  // clock and reset
  input  wire logic       clk,
  input  wire logic       rst_n,
  // control
  input  wire logic       run,
  input  wire logic [2:0] sel,
  // converter clock enable
  output logic            tick
);
  logic [CNT_W-1:0] cnt;
  logic [CNT_W-1:0] lim;

  // divide by two for both low codes, else by two to the code
  function automatic logic [CNT_W-1:0] div_limit(input logic [2:0] s);
    logic [CNT_W:0] d;
    d = (s == `ADCC_PS_DIV2) ? (CNT_W+1)'(2) : (CNT_W+1)'(1) << s;
    return CNT_W'(d - (CNT_W+1)'(1));
  endfunction

  assign lim = div_limit(sel);

  // counter held at zero while stopped, so it restarts cleanly
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt  <= '0;
      tick <= 1'b0;
    end else if (!run) begin
      cnt  <= '0;
      tick <= 1'b0;
    end else if (cnt >= lim) begin
      cnt  <= '0;
      tick <= 1'b1;
    end else begin
      cnt  <= cnt + CNT_W'(1);
      tick <= 1'b0;
    end
  end
endmodule // adcc_prescale

/* src/adcc_sar.sv */
// adc control successive approximation sequencer
// assumes comp_high is high when the input is at or above the dac level
`timescale 1ns/100ps
`include "adcc_cfg.svh"
module adcc_sar
  import adcc_pkg::*;
#(
  parameter int RES_W = 10
) (
  // clock and reset
  input  wire logic             clk,
  input  wire logic             rst_n,
  // control
  input  wire logic             tick,
  input  wire logic             start,
  input  wire logic             abort,
  input  wire logic             first,
  input  wire logic             comp_high,
  // status and analog drive
  output logic                  busy,
  output logic                  done,
  output logic                  sample_hold,
  output logic [RES_W-1:0]      dac_code,
  output logic [RES_W-1:0]      result
);
  localparam logic [4:0] INIT_N = `ADCC_CONV_FIRST - `ADCC_CONV_NORM;
  localparam logic [4:0] SAMP_N = `ADCC_CONV_NORM - 5'(RES_W);

  adcc_sar_st_t     state;
  logic [4:0]       cnt;
  logic [RES_W-1:0] mask;
  logic [RES_W-1:0] kept;

  // keep the trial bit only when the input reaches the dac level
  assign kept = comp_high ? dac_code : (dac_code & ~mask);

  // init, sample, then one trial per converter clock, msb first
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state       <= SAR_IDLE;
      cnt         <= '0;
      mask        <= '0;
      busy        <= 1'b0;
      done        <= 1'b0;
      sample_hold <= 1'b0;
      dac_code    <= '0;
      result      <= '0;
    end else if (abort) begin
      state       <= SAR_IDLE;
      busy        <= 1'b0;
      done        <= 1'b0;
      sample_hold <= 1'b0;
      dac_code    <= '0;
    end else begin
      done <= 1'b0;
      case (state)
        SAR_IDLE: if (start) begin
          busy        <= 1'b1;
          state       <= first ? SAR_INIT : SAR_SAMPLE;
          cnt         <= (first ? INIT_N : SAMP_N) - 5'h01;
          sample_hold <= !first;
        end
        SAR_INIT: if (tick) begin
          if (cnt == '0) begin
            state       <= SAR_SAMPLE;
            cnt         <= SAMP_N - 5'h01;
            sample_hold <= 1'b1;
          end else cnt <= cnt - 5'h01;
        end
        SAR_SAMPLE: if (tick) begin
          if (cnt == '0) begin
            state       <= SAR_TRIAL;
            sample_hold <= 1'b0;
            mask        <= {1'b1, {(RES_W-1){1'b0}}};
            dac_code    <= {1'b1, {(RES_W-1){1'b0}}};
          end else cnt <= cnt - 5'h01;
        end
        SAR_TRIAL: if (tick) begin
          if (mask[0]) begin
            result   <= kept;
            done     <= 1'b1;
            busy     <= 1'b0;
            dac_code <= '0;
            state    <= SAR_IDLE;
          end else begin
            mask     <= mask >> 1;
            dac_code <= kept | (mask >> 1);
          end
        end
        default: state <= SAR_IDLE;
      endcase
    end
  end
endmodule // adcc_sar

/* src/adcc_top.sv */
// adc control top: apb register file, trigger logic, result hold, analog drive
// assumes apb master at pclk, inputs synchronous to pclk, 8-bit data in lane 0
`timescale 1ns/100ps
`include "adcc_cfg.svh"
// Functional notes
// - result is input times 1024 over reference, 0x000 ground, 0x3ff top
// - completion updates result registers and sets the completion flag
// - channel code 1000 connects and enables the temperature sensor
// - reference 00 external pin, 01 analog supply, 10 reserved, 11 internal
// - reference change during a conversion applies after it completes
// - channel change during a conversion applies after it completes
// - channels 0-7 external, 8 temperature, 14 bandgap, 15 ground, rest reserved
// - left adjust bit changes the result view at once
// - enable powers up; clearing it turns off and aborts a conversion
// - start begins one conversion; in free running only the first
// - first conversion after enabling takes 25 clocks, later ones 13
// - start reads one while converting, zero after; writing zero does nothing
// - auto trigger starts a conversion on each rising edge of chosen trigger while no conversion is pending or running
// - interrupt request when flag, interrupt enable and global enable are set
// - flag clears on vector acknowledge or when written with one
// - prescaler codes 000 and 001 divide by 2, then 4 up to 128
// - selecting free running source makes no trigger event by itself
// - after low byte read, result is held until high byte is read
module adcc_top
  import adcc_pkg::*;
#(
  parameter int RES_W   = 10,
  parameter int PRESC_W = 7,
  parameter int TRIG_N  = 7
) (
  // clock and reset
  input  wire logic              pclk,
  input  wire logic              presetn,
  // apb slave
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [11:0]       paddr,
  input  wire logic [31:0]       pwdata,
  input  wire logic [3:0]        pstrb,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  // cpu side
  input  wire logic              global_irq_en,
  input  wire logic              irq_ack,
  output logic                   irq,
  // trigger sources, index is source code minus one
  input  wire logic [TRIG_N-1:0] trigger_in,
  // analog front end
  input  wire logic              comp_high,
  output adcc_anlg_t             analog
);
  // register state
  logic             converter_enable;
  logic             auto_trigger_enable;
  logic             conversion_done_flag;
  logic             conversion_irq_enable;
  logic [2:0]       clock_prescale_select;
  logic [2:0]       trigger_source_select;
  logic [1:0]       reference_select;
  logic             left_adjust;
  logic [3:0]       channel_select;
  // conversion state
  logic             start_pend;
  logic             first_pend;
  logic [1:0]       act_ref;
  logic [3:0]       act_chan;
  logic [RES_W-1:0] result;
  logic             res_lock;
  logic             trig_prev;
  logic [13:0]      sel_q;
  logic             ref_ext_q;
  // wires
  logic             tick;
  logic             sar_busy;
  logic             sar_done;
  logic             sar_sample;
  logic [RES_W-1:0] sar_dac;
  logic [RES_W-1:0] sar_result;
  logic             setup;
  logic             wr;
  logic             rd;
  logic             w_ctrl;
  logic             w_ctrl_b;
  logic             w_sel;
  logic             next_enable;
  logic             next_flag;
  logic             idle;
  logic             sel_trig;
  logic             trig_fire;
  logic             free_restart;
  logic [7:0]       view_lo;
  logic [7:0]       view_hi;
  logic [7:0]       rd_view;
  logic             mapped;

  // word hit on a register index, misaligned addresses never hit
  function automatic logic hit(input logic [11:0] a, input logic [9:0] idx);
    return (a[1:0] == 2'h0) && (a[11:2] == idx);
  endfunction

  // converter clock enable
  adcc_prescale #(
    .CNT_W (PRESC_W)
  ) u_presc (
    .clk   (pclk),
    .rst_n (presetn),
    .run   (converter_enable),
    .sel   (clock_prescale_select),
    .tick  (tick)
  );

  // approximation sequencer
  adcc_sar #(
    .RES_W (RES_W)
  ) u_sar (
    .clk         (pclk),
    .rst_n       (presetn),
    .tick        (tick),
    .start       (start_pend),
    .abort       (!converter_enable),
    .first       (first_pend),
    .comp_high   (comp_high),
    .busy        (sar_busy),
    .done        (sar_done),
    .sample_hold (sar_sample),
    .dac_code    (sar_dac),
    .result      (sar_result)
  );

  // apb phase and register strobes
  assign setup    = psel && !penable;
  assign wr       = psel && penable && pready && pwrite && pstrb[0];
  assign rd       = psel && penable && pready && !pwrite;
  assign w_ctrl   = wr && hit(paddr, `ADCC_IDX_CTRL);
  assign w_ctrl_b = wr && hit(paddr, `ADCC_IDX_CTRL_B);
  assign w_sel    = wr && hit(paddr, `ADCC_IDX_SEL);
  assign mapped   = hit(paddr, `ADCC_IDX_RES_LO) || hit(paddr, `ADCC_IDX_RES_HI) ||
                    hit(paddr, `ADCC_IDX_CTRL) || hit(paddr, `ADCC_IDX_CTRL_B) ||
                    hit(paddr, `ADCC_IDX_SEL);

  // result view follows left adjust live
  assign view_lo = left_adjust ? {result[1:0], 6'h00} : result[7:0];
  assign view_hi = left_adjust ? result[9:2] : {6'h00, result[9:8]};

  // read data mux
  always_comb begin
    rd_view = 8'h00;
    if (hit(paddr, `ADCC_IDX_RES_LO)) rd_view = view_lo;
    else if (hit(paddr, `ADCC_IDX_RES_HI)) rd_view = view_hi;
    else if (hit(paddr, `ADCC_IDX_CTRL))
      rd_view = {converter_enable, start_pend || sar_busy, auto_trigger_enable,
                 conversion_done_flag, conversion_irq_enable, clock_prescale_select};
    else if (hit(paddr, `ADCC_IDX_CTRL_B)) rd_view = {5'h00, trigger_source_select};
    else if (hit(paddr, `ADCC_IDX_SEL))
      rd_view = {reference_select, left_adjust, 1'b0, channel_select};
  end

  // apb answer, one access cycle, error on unmapped words
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      prdata  <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else begin
      pready <= setup;
      if (setup) begin
        prdata  <= {24'h00_0000, rd_view};
        pslverr <= !mapped;
      end
    end
  end

  // control/status writes, start and flag handled apart
  assign next_enable = w_ctrl ? pwdata[`ADCC_CS_EN] : converter_enable;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      converter_enable      <= 1'b0;
      auto_trigger_enable   <= 1'b0;
      conversion_irq_enable <= 1'b0;
      clock_prescale_select <= 3'h0;
    end else if (w_ctrl) begin
      converter_enable      <= pwdata[`ADCC_CS_EN];
      auto_trigger_enable   <= pwdata[`ADCC_CS_ATE];
      conversion_irq_enable <= pwdata[`ADCC_CS_IE];
      clock_prescale_select <= pwdata[`ADCC_CS_PS];
    end
  end

  // trigger source and channel/reference select writes
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      trigger_source_select <= 3'h0;
      reference_select      <= 2'h0;
      left_adjust           <= 1'b0;
      channel_select        <= 4'h0;
    end else begin
      if (w_ctrl_b) trigger_source_select <= pwdata[`ADCC_CB_TS];
      if (w_sel) begin
        reference_select <= pwdata[`ADCC_SEL_REF];
        left_adjust      <= pwdata[`ADCC_SEL_LADJ];
        channel_select   <= pwdata[`ADCC_SEL_CH];
      end
    end
  end

  // trigger edge on the chosen source, free running uses completion
  assign sel_trig     = (trigger_source_select == `ADCC_TS_FREE) ? 1'b0 :
                        trigger_in[trigger_source_select - 3'h1];
  assign trig_fire    = auto_trigger_enable && sel_trig && !trig_prev;
  assign free_restart = auto_trigger_enable && sar_done &&
                        (trigger_source_select == `ADCC_TS_FREE);
  assign idle         = !sar_busy && !start_pend;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) trig_prev <= 1'b0;
    else trig_prev <= sel_trig;
  end

  // start request, taken by the sequencer while it is idle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) start_pend <= 1'b0;
    else if (!next_enable) start_pend <= 1'b0;
    else if (idle && w_ctrl && pwdata[`ADCC_CS_START]) start_pend <= 1'b1;
    else if (idle && (trig_fire || free_restart)) start_pend <= 1'b1;
    else if (!sar_busy) start_pend <= 1'b0;
  end

  // first conversion after enabling runs the long sequence
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) first_pend <= 1'b0;
    else if (w_ctrl && pwdata[`ADCC_CS_EN] && !converter_enable) first_pend <= 1'b1;
    else if (start_pend && !sar_busy) first_pend <= 1'b0;
  end

  // completion flag, a set in the clearing cycle wins
  assign next_flag = sar_done || (conversion_done_flag &&
                     !(irq_ack || (w_ctrl && pwdata[`ADCC_CS_FLAG])));
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) conversion_done_flag <= 1'b0;
    else conversion_done_flag <= next_flag;
  end

  // interrupt request
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) irq <= 1'b0;
    else irq <= conversion_done_flag && conversion_irq_enable && global_irq_en;
  end

  // result capture and low/high read lock
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      result   <= '0;
      res_lock <= 1'b0;
    end else begin
      if (sar_done && !res_lock) result <= sar_result;
      if (rd && hit(paddr, `ADCC_IDX_RES_HI)) res_lock <= 1'b0;
      else if (rd && hit(paddr, `ADCC_IDX_RES_LO)) res_lock <= 1'b1;
    end
  end

  // applied selects change only between conversions
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      act_ref  <= 2'h0;
      act_chan <= 4'h0;
    end else if (!sar_busy) begin
      act_ref  <= reference_select;
      act_chan <= channel_select;
    end
  end

  // decoded mux and reference drive
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sel_q     <= 14'h0000;
      ref_ext_q <= 1'b0;
    end else begin
      sel_q[13]   <= converter_enable;
      for (int i = 0; i < 8; i++) sel_q[5+i] <= (act_chan == 4'(i));
      sel_q[4]    <= (act_chan == `ADCC_CH_TEMP);
      sel_q[3]    <= (act_chan == `ADCC_CH_BG);
      sel_q[2]    <= (act_chan == `ADCC_CH_GND);
      sel_q[1]    <= (act_ref == `ADCC_REF_AVCC);
      sel_q[0]    <= (act_ref == `ADCC_REF_INT);
      ref_ext_q   <= converter_enable && (act_ref == `ADCC_REF_EXT);
    end
  end

  // analog bundle, all fields from flops
  always_comb begin
    analog             = '0;
    analog.power_on    = sel_q[13];
    analog.sample_hold = sar_sample;
    analog.dac_code    = sar_dac;
    analog.ext_sel     = sel_q[12:5];
    analog.temp_en     = sel_q[4];
    analog.bandgap_sel = sel_q[3];
    analog.ground_sel  = sel_q[2];
    analog.ref_ext     = ref_ext_q;
    analog.ref_avcc    = sel_q[1];
    analog.ref_int     = sel_q[0];
  end

  // converter clocks counted per conversion, checking only
  logic [4:0] tcnt;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) tcnt <= 5'h00;
    else if (!sar_busy) tcnt <= 5'h00;
    else if (tick) tcnt <= tcnt + 5'h01;
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  flag_on_done_a: assert property (sar_done |=> conversion_done_flag)
    else $error("flag not set after completion");
  result_load_a: assert property (sar_done && !res_lock |=> result == $past(sar_result))
    else $error("result not loaded");
  lock_hold_a: assert property (res_lock && sar_done |=> $stable(result))
    else $error("locked result changed");
  temp_drive_a: assert property (act_chan == `ADCC_CH_TEMP |=> analog.temp_en)
    else $error("temperature sensor not enabled");
  ref_hold_a: assert property (sar_busy && $past(sar_busy) |-> $stable(act_ref))
    else $error("reference changed mid conversion");
  chan_hold_a: assert property (sar_busy && $past(sar_busy) |-> $stable(act_chan))
    else $error("channel changed mid conversion");
  abort_stop_a: assert property (!converter_enable && !next_enable |=> !sar_busy && !start_pend)
    else $error("conversion survived disable");
  conv_len_a: assert property (sar_done |-> tcnt == `ADCC_CONV_NORM || tcnt == `ADCC_CONV_FIRST)
    else $error("conversion length wrong");
  start_take_a: assert property (start_pend && !sar_busy && converter_enable |=> sar_busy)
    else $error("start not taken");
  irq_raise_a: assert property (conversion_done_flag && conversion_irq_enable
                                && global_irq_en |=> irq)
    else $error("irq not raised");
  ack_clear_a: assert property (irq_ack && !sar_done |=> !conversion_done_flag)
    else $error("flag not cleared by ack");
  div4_period_a: assert property ((tick && converter_enable && clock_prescale_select == 3'h2)
                   ##1 (converter_enable && clock_prescale_select == 3'h2) [*4] |-> tick)
    else $error("divide by four period wrong");
  off_no_tick_a: assert property (!converter_enable |=> !tick)
    else $error("prescaler ran while off");

  first_done_c: cover property (first_pend && start_pend ##[1:400] sar_done);
  free_run_c: cover property (free_restart ##[1:300] sar_done);
  lock_c: cover property (res_lock && sar_done);
  abort_c: cover property (sar_busy && !converter_enable);
endmodule // adcc_top

/* tb/adcc_front_model.sv */
// analog front end model: input levels per channel and the comparator
// assumes the block drives adcc_anlg_t and samples comp_high on pclk
`timescale 1ns/100ps
module adcc_front_model
  import adcc_pkg::*;
(
  // drive from the block
  input  wire adcc_anlg_t analog,
  // comparator answer
  output logic            comp_high
);
  logic [9:0] vin;
  // level of the selected source, in reference counts
  always_comb begin
    vin = 10'h2aa; // nothing selected: floating pattern
    for (int i = 0; i < 8; i++)
      if (analog.ext_sel[i]) vin = 10'h05b * 10'(i + 1);
    if (analog.temp_en) vin = 10'h10e;
    if (analog.bandgap_sel) vin = 10'h2a5;
    if (analog.ground_sel) vin = 10'h000;
  end
  // comparator against the trial level, silent while powered down
  assign comp_high = analog.power_on & (vin >= analog.dac_code);
endmodule // adcc_front_model

/* tb/adc_conversion_control_tb.sv */
// testbench for the adc control block: apb tasks and directed tests
// assumes src/ on the include path and the front end model beside it
`timescale 1ns/100ps
`include "adcc_cfg.svh"
module adc_conversion_control_tb;
  import adcc_pkg::*;
  localparam logic [11:0] A_LO = {`ADCC_IDX_RES_LO, 2'b00};
  localparam logic [11:0] A_HI = {`ADCC_IDX_RES_HI, 2'b00};
  localparam logic [11:0] A_CS = {`ADCC_IDX_CTRL, 2'b00};
  localparam logic [11:0] A_CB = {`ADCC_IDX_CTRL_B, 2'b00};
  localparam logic [11:0] A_SL = {`ADCC_IDX_SEL, 2'b00};
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic        global_irq_en, irq_ack, irq, comp_high, rd_e;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd_v;
  logic [3:0]  pstrb;
  logic [6:0]  trigger_in;
  adcc_anlg_t  analog;
  int          errors, comparisons;
  realtime     t0;

  adcc_top dut_u (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb,
    .prdata, .pready, .pslverr, .global_irq_en, .irq_ack, .irq, .trigger_in,
    .comp_high, .analog);
  adcc_front_model model_u (.analog, .comp_high);

  // one apb transfer, held until pready is taken
  task automatic xfer(input logic w, input logic [11:0] a, input logic [7:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h0, d};
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    for (int n = 0; n < 20 && pready !== 1'b1; n++) @(posedge pclk);
    if (pready !== 1'b1) begin
      errors++;
      $display("unexpected at %0t: no pready", $time);
    end
    rd_v = prdata;
    rd_e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // value comparison
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    comparisons++;
    if (got !== exp) begin
      errors++;
      $display("unexpected at %0t: %s got %h expected %h", $time, m, got, exp);
    end
  endtask
  // read and compare
  task automatic rd(input logic [11:0] a, input logic [31:0] exp, input string m);
    xfer(1'b0, a, 8'h00);
    chk(rd_v, exp, m);
  endtask
  // poll control/status until the flag shows, bounded
  task automatic wait_done;
    rd_v = '0;
    for (int n = 0; n < 100 && rd_v[4] !== 1'b1; n++) xfer(1'b0, A_CS, 8'h00);
    chk(32'(rd_v[4]), 32'h1, "flag timeout");
  endtask
  // verdict and end of run
  task automatic complete_run;
    $display("comparisons %0d errors %0d", comparisons, errors);
    if (errors == 0 && comparisons > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  // clock at 8 ns
  initial begin
    pclk = 1'b0;
    forever #4 pclk = ~pclk;
  end
  // watchdog against a hang
  initial begin
    #64000;
    errors++;
    complete_run;
  end
  // test sequence
  initial begin
    {psel, penable, pwrite, global_irq_en, irq_ack, presetn} = '0;
    paddr = '0;
    pwdata = '0;
    pstrb = 4'h1;
    trigger_in = '0;
    rd_v = '0;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    rd(A_CS, 32'h0, "cs reset");
    rd(A_SL, 32'h0, "sel reset");
    rd(A_HI, 32'h0, "high reset");
    rd(12'h1f8, 32'h0, "unmapped data");
    chk(32'(rd_e), 32'h1, "unmapped error");
    $display("test reset done");
    xfer(1'b1, A_SL, 8'h43);
    t0 = $realtime;
    xfer(1'b1, A_CS, 8'hc0);
    chk(32'({analog.ext_sel, analog.ref_ext, analog.ref_avcc, analog.ref_int}), 32'h42, "sel");
    rd(A_CS, 32'hc0, "start busy");
    wait_done;
    chk(32'(($realtime - t0) >= 400.0), 32'h1, "first length");
    rd(A_CS, 32'h90, "flag set");
    rd(A_LO, 32'h6c, "low");
    rd(A_HI, 32'h01, "high");
    global_irq_en <= 1'b1;
    xfer(1'b1, A_CS, 8'h88);
    rd(A_CS, 32'h98, "flag kept");
    chk(32'(irq), 32'h1, "irq raised");
    global_irq_en <= 1'b0;
    repeat (2) @(negedge pclk);
    chk(32'(irq), 32'h0, "irq masked");
    @(posedge pclk);
    irq_ack <= 1'b1;
    @(posedge pclk);
    irq_ack <= 1'b0;
    rd(A_CS, 32'h88, "ack clears");
    $display("test first conversion done");
    xfer(1'b1, A_SL, 8'hc8);
    t0 = $realtime;
    xfer(1'b1, A_CS, 8'hc8);
    chk(32'(analog.temp_en & analog.ref_int), 32'h1, "temp on");
    wait_done;
    chk(32'(($realtime - t0) < 400.0), 32'h1, "later length");
    xfer(1'b1, A_SL, 8'he8);
    rd(A_LO, 32'h80, "left low");
    rd(A_HI, 32'h43, "left high");
    xfer(1'b1, A_CS, 8'h98);
    rd(A_CS, 32'h88, "w1c");
    xfer(1'b1, A_SL, 8'h4f);
    xfer(1'b1, A_CS, 8'hc0);
    xfer(1'b1, A_SL, 8'hc1);
    repeat (4) @(posedge pclk);
    chk(32'({analog.ext_sel, analog.ref_ext, analog.ref_avcc, analog.ref_int}), 32'h2, "held");
    wait_done;
    rd(A_LO, 32'h0, "ground low");
    rd(A_HI, 32'h0, "ground high");
    xfer(1'b1, A_SL, 8'h4e);
    xfer(1'b1, A_CS, 8'hd0);
    wait_done;
    rd(A_LO, 32'ha5, "bandgap low");
    rd(A_HI, 32'h02, "bandgap high");
    $display("test select hold done");
    xfer(1'b1, A_CS, 8'hd0);
    xfer(1'b1, A_CS, 8'h00);
    repeat (80) @(posedge pclk);
    rd(A_CS, 32'h0, "aborted");
    chk(32'(analog.power_on), 32'h0, "power off");
    xfer(1'b1, A_CB, 8'h01);
    xfer(1'b1, A_CS, 8'ha2);
    t0 = $realtime;
    trigger_in <= 7'h01;
    wait_done;
    chk(32'(($realtime - t0) >= 800.0), 32'h1, "div4 length");
    rd(A_CS, 32'hb2, "triggered");
    xfer(1'b1, A_CB, 8'h00);
    repeat (4) @(posedge pclk);
    rd(A_CS, 32'hb2, "no free start");
    $display("test abort and trigger done");
    complete_run;
  end
endmodule // adc_conversion_control_tb
